// *** pmc_pkg.sv ***
// Purpose: constants and types for the power mode controller
// Assumes: single 25 MHz clock, no software-visible registers
// Notes: mode and state codes shared by design and verification
//
// What this block does
// - active mode powers cpu, radio, always-on domain and coprocessor
// - modem-sleep runs cpu with configurable clock, radio off, rest on
// - light-sleep pauses cpu, radio off, always-on and coprocessor run
// - light-sleep wakes on enabled mac, host, timer or external interrupt
// - deep-sleep powers only always-on domain; coprocessor optional
// - connection data retained in always-on memory through deep-sleep
// - hibernation stops fast oscillator, coprocessor and recovery memory
// - hibernation wakes only on slow timer or always-on gpio
// - association pattern alternates active and modem-sleep on interval
// - sensor pattern keeps cpu in deep-sleep, coprocessor may wake system
// - wireless enabled alternates active and modem-sleep
// - modem-sleep cpu clock follows load: max, normal or slow
// - deep-sleep with coprocessor keeps gpio alive
// - sensor pattern runs converter at one percent duty
// - power-up pin low forces power-off in any mode
// - always-on fast memory reachable by cpu during wake boot
// - always-on slow memory powered for coprocessor during deep-sleep
// - chip enable active high; device runs only while asserted
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_ACTIVE = 3'h0,
        PMC_MODEM = 3'h1,
        PMC_LIGHT = 3'h2,
        PMC_DEEP = 3'h3,
        PMC_HIBER = 3'h4,
        PMC_OFF = 3'h5,
        PMC_BOOT = 3'h6
    } pmc_state_t;

    typedef enum logic [1:0] {
        PMC_SPD_MAX = 2'h0,
        PMC_SPD_NORMAL = 2'h1,
        PMC_SPD_SLOW = 2'h2
    } pmc_speed_t;

    // wake source bit positions
    localparam int PMC_WK_MAC = 0;
    localparam int PMC_WK_HOST = 1;
    localparam int PMC_WK_TIMER = 2;
    localparam int PMC_WK_EXT = 3;
    localparam int PMC_WK_N = 4;

    // cpu load thresholds for speed selection
    localparam logic [7:0] PMC_LOAD_HI = 8'hC0;
    localparam logic [7:0] PMC_LOAD_LO = 8'h20;

    // converter duty: 1 of 100 periods
    localparam logic [6:0] PMC_DUTY_ON = 7'h01;
    localparam logic [6:0] PMC_DUTY_PERIOD = 7'h64;

    // boot count at which the 9-cycle boot path ends
    localparam logic [3:0] PMC_BOOT_CYC = 4'h8;
endpackage

// *** pmc_ctrl.sv ***
// Purpose: power mode sequencer gating domains per mode
// Assumes: inputs synchronous to clock; slow timer expiry comes in as a pulse
// Notes: domain enables are registered; all outputs from flip-flops
`timescale 1ns/100ps
module pmc_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // supply pins
    input wire logic power_up_pin,
    input wire logic chip_en,
    // software requests
    input wire logic sleep_req,
    input wire pmc_pkg::pmc_state_t sleep_target,
    input wire logic copro_keep,
    input wire logic [pmc_pkg::PMC_WK_N-1:0] wake_en,
    input wire logic wireless_en,
    input wire logic assoc_en,
    input wire logic sensor_en,
    input wire logic [7:0] cpu_load,
    input wire logic periph_fast,
    // wake sources
    input wire logic [pmc_pkg::PMC_WK_N-1:0] wake_evt,
    input wire logic slow_timer_exp,
    input wire logic [7:0] aon_gpio_wake,
    input wire logic copro_wake,
    input wire logic modem_idle,
    input wire logic modem_due,
    // domain controls
    output logic cpu_pwr,
    output logic cpu_run,
    output logic cpu_boot,
    output logic radio_pwr,
    output logic aon_pwr,
    output logic aon_fast_mem_cpu,
    output logic aon_slow_mem_pwr,
    output logic aon_recovery_pwr,
    output logic copro_pwr,
    output logic fast_osc_en,
    output logic slow_timer_en,
    output logic aon_gpio_en,
    output logic adc_run,
    output pmc_pkg::pmc_speed_t cpu_speed,
    output pmc_pkg::pmc_state_t mode
);
    pmc_pkg::pmc_state_t state_r, state_nxt;
    logic copro_keep_r, copro_keep_nxt;
    logic [3:0] boot_cnt_r, boot_cnt_nxt;
    logic [6:0] duty_cnt_r;
    pmc_pkg::pmc_speed_t speed_nxt;

    wire power_ok = power_up_pin & chip_en;
    // enabled wake events, one gate per source
    wire [pmc_pkg::PMC_WK_N-1:0] wake_hit;
    for (genvar i = 0; i < pmc_pkg::PMC_WK_N; i++) begin : g_wake
        assign wake_hit[i] = wake_evt[i] & wake_en[i];
    end
    wire light_wake = |wake_hit;
    wire hiber_wake = slow_timer_exp | (|aon_gpio_wake);
    wire deep_wake = hiber_wake | (copro_keep_r & copro_wake);
    wire sleep_ok = sleep_req & (sleep_target == pmc_pkg::PMC_LIGHT
        || sleep_target == pmc_pkg::PMC_DEEP || sleep_target == pmc_pkg::PMC_HIBER
        || sleep_target == pmc_pkg::PMC_MODEM);
    wire boot_done = (boot_cnt_r == pmc_pkg::PMC_BOOT_CYC);

    always_comb begin
        state_nxt = state_r;
        copro_keep_nxt = copro_keep_r;
        boot_cnt_nxt = 4'h0;
        case (state_r)
            pmc_pkg::PMC_OFF: begin
                state_nxt = pmc_pkg::PMC_BOOT;
            end
            pmc_pkg::PMC_BOOT: begin
                boot_cnt_nxt = boot_cnt_r + 4'h1;
                if (boot_done) begin
                    state_nxt = pmc_pkg::PMC_ACTIVE;
                end
            end
            pmc_pkg::PMC_ACTIVE: begin
                if (sleep_ok) begin
                    state_nxt = sleep_target;
                    copro_keep_nxt = copro_keep;
                end else if ((wireless_en | assoc_en) & modem_idle) begin
                    state_nxt = pmc_pkg::PMC_MODEM;
                end
            end
            pmc_pkg::PMC_MODEM: begin
                if (modem_due) begin
                    state_nxt = pmc_pkg::PMC_ACTIVE;
                end else if (sleep_ok && sleep_target != pmc_pkg::PMC_MODEM) begin
                    state_nxt = sleep_target;
                    copro_keep_nxt = copro_keep;
                end
            end
            pmc_pkg::PMC_LIGHT: begin
                if (light_wake) begin
                    state_nxt = pmc_pkg::PMC_ACTIVE;
                end
            end
            pmc_pkg::PMC_DEEP: begin
                if (deep_wake) begin
                    state_nxt = pmc_pkg::PMC_BOOT;
                end
            end
            pmc_pkg::PMC_HIBER: begin
                if (hiber_wake) begin
                    state_nxt = pmc_pkg::PMC_BOOT;
                end
            end
            default: begin
                state_nxt = pmc_pkg::PMC_OFF;
            end
        endcase
    end

    always_comb begin
        if (cpu_load >= pmc_pkg::PMC_LOAD_HI) begin
            speed_nxt = pmc_pkg::PMC_SPD_MAX;
        end else if (cpu_load > pmc_pkg::PMC_LOAD_LO || periph_fast) begin
            speed_nxt = pmc_pkg::PMC_SPD_NORMAL;
        end else begin
            speed_nxt = pmc_pkg::PMC_SPD_SLOW;
        end
    end

    // state decode
    wire in_active = (state_r == pmc_pkg::PMC_ACTIVE);
    wire in_modem = (state_r == pmc_pkg::PMC_MODEM);
    wire in_light = (state_r == pmc_pkg::PMC_LIGHT);
    wire in_deep = (state_r == pmc_pkg::PMC_DEEP);
    wire in_boot = (state_r == pmc_pkg::PMC_BOOT);
    wire in_off = (state_r == pmc_pkg::PMC_OFF);
    wire awake = in_active | in_modem | in_boot;
    wire duty_wrap = (duty_cnt_r == pmc_pkg::PMC_DUTY_PERIOD - 7'h1);
    wire [6:0] duty_cnt_nxt = duty_wrap ? 7'h00 : duty_cnt_r + 7'h01;
    wire adc_on = in_deep & copro_keep_r & sensor_en & (duty_cnt_r < pmc_pkg::PMC_DUTY_ON);

    // next values of the domain enables
    wire cpu_pwr_nxt = awake | in_light;
    wire cpu_run_nxt = in_active | in_modem;
    wire fast_mem_nxt = in_boot | in_active | in_modem;
    wire radio_pwr_nxt = in_active;
    wire aon_pwr_nxt = awake | in_light | in_deep;
    wire copro_pwr_nxt = awake | in_light | (in_deep & copro_keep_r);
    wire fast_osc_nxt = awake | in_light | in_deep;
    // slow timer and gpio are the last things alive before power-off
    wire aon_wake_nxt = !in_off;

    // state held through power loss only as off; a new boot follows release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= pmc_pkg::PMC_OFF;
        end else if (!power_ok) begin
            state_r <= pmc_pkg::PMC_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // coprocessor choice per sleep
    // dropped on power loss so a cold start never keeps it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            copro_keep_r <= 1'h0;
        end else if (!power_ok) begin
            copro_keep_r <= 1'h0;
        end else begin
            copro_keep_r <= copro_keep_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            boot_cnt_r <= 4'h0;
        end else if (!power_ok) begin
            boot_cnt_r <= 4'h0;
        end else begin
            boot_cnt_r <= boot_cnt_nxt;
        end
    end

    // duty counter
    // free-running: first strobe may come up to one period after entry
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            duty_cnt_r <= 7'h00;
        end else if (!power_ok) begin
            duty_cnt_r <= 7'h00;
        end else begin
            duty_cnt_r <= duty_cnt_nxt;
        end
    end

    // mode mirrors the state one edge late
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode <= pmc_pkg::PMC_OFF;
        end else begin
            mode <= state_r;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_pwr <= 1'h0;
        end else begin
            cpu_pwr <= cpu_pwr_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_run <= 1'h0;
        end else begin
            cpu_run <= cpu_run_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_boot <= 1'h0;
        end else begin
            cpu_boot <= in_boot;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aon_fast_mem_cpu <= 1'h0;
        end else begin
            aon_fast_mem_cpu <= fast_mem_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            radio_pwr <= 1'h0;
        end else begin
            radio_pwr <= radio_pwr_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aon_pwr <= 1'h0;
        end else begin
            aon_pwr <= aon_pwr_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aon_slow_mem_pwr <= 1'h0;
        end else begin
            aon_slow_mem_pwr <= aon_pwr_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aon_recovery_pwr <= 1'h0;
        end else begin
            aon_recovery_pwr <= aon_pwr_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            copro_pwr <= 1'h0;
        end else begin
            copro_pwr <= copro_pwr_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fast_osc_en <= 1'h0;
        end else begin
            fast_osc_en <= fast_osc_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slow_timer_en <= 1'h0;
        end else begin
            slow_timer_en <= aon_wake_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aon_gpio_en <= 1'h0;
        end else begin
            aon_gpio_en <= aon_wake_nxt;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            adc_run <= 1'h0;
        end else begin
            adc_run <= adc_on;
        end
    end

    // speed follows load only in modem-sleep
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_speed <= pmc_pkg::PMC_SPD_MAX;
        end else if (in_modem) begin
            cpu_speed <= speed_nxt;
        end else begin
            cpu_speed <= pmc_pkg::PMC_SPD_MAX;
        end
    end
endmodule

// *** pmc_ctrl_props.sv ***
// Purpose: mode gating and wake timing checks at the pmc_ctrl ports
// Assumes: outputs and mode follow the state one edge late
// Notes: bound below to every pmc_ctrl
`timescale 1ns/100ps
module pmc_ctrl_props (
    // watched ports
    input wire logic clock,
    input wire logic nrst,
    input wire logic power_up_pin,
    input wire logic chip_en,
    input wire logic [pmc_pkg::PMC_WK_N-1:0] wake_en,
    input wire logic [pmc_pkg::PMC_WK_N-1:0] wake_evt,
    input wire logic slow_timer_exp,
    input wire logic cpu_pwr,
    input wire logic cpu_run,
    input wire logic cpu_boot,
    input wire logic radio_pwr,
    input wire logic aon_pwr,
    input wire logic aon_recovery_pwr,
    input wire logic copro_pwr,
    input wire logic fast_osc_en,
    input wire pmc_pkg::pmc_state_t mode
);
    wire logic ok = power_up_pin && chip_en;
    wire logic lw = (wake_evt & wake_en) != '0;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    act_gate_a: assert property (mode == pmc_pkg::PMC_ACTIVE |->
        cpu_run && radio_pwr && aon_pwr && copro_pwr) else $error("active gating wrong");
    modem_gate_a: assert property (mode == pmc_pkg::PMC_MODEM |->
        cpu_run && !radio_pwr && aon_pwr && copro_pwr) else $error("modem gating wrong");
    light_gate_a: assert property (mode == pmc_pkg::PMC_LIGHT |->
        cpu_pwr && !cpu_run && !radio_pwr && aon_pwr && copro_pwr) else $error("light gating");
    deep_gate_a: assert property (mode == pmc_pkg::PMC_DEEP |->
        !cpu_pwr && !radio_pwr && aon_pwr) else $error("deep gating wrong");
    hiber_gate_a: assert property (mode == pmc_pkg::PMC_HIBER |->
        !fast_osc_en && !copro_pwr && !aon_recovery_pwr && !aon_pwr) else $error("hiber gating");
    power_off_a: assert property (!ok |-> ##2 mode == pmc_pkg::PMC_OFF)
        else $error("no power off");
    light_wake_a: assert property (mode == pmc_pkg::PMC_LIGHT && lw && ok |->
        ##2 cpu_run && !cpu_boot) else $error("light wake missed");
    deep_wake_a: assert property (mode == pmc_pkg::PMC_DEEP && slow_timer_exp && ok |->
        ##2 cpu_boot [*8] ##[1:3] cpu_run) else $error("deep wake boot wrong");
    cover property (mode == pmc_pkg::PMC_LIGHT && lw);
    cover property (mode == pmc_pkg::PMC_DEEP && slow_timer_exp);
    cover property (mode == pmc_pkg::PMC_HIBER);
endmodule
bind pmc_ctrl pmc_ctrl_props u_props (.*);

// *** pmc_wake_src.sv ***
// Purpose: wake sources raising one line while the bench holds a code
// Assumes: code moves just after a rising edge
// Notes: 1-4 event bits, 5 timer, 6 gpio, 7 coprocessor
`timescale 1ns/100ps
module pmc_wake_src (
    // code in, wake lines out
    input wire logic [2:0] fire,
    output logic [3:0] wake_evt,
    output logic slow_timer_exp,
    output logic [7:0] aon_gpio_wake,
    output logic copro_wake
);
    assign wake_evt = (fire != 3'h0 && fire < 3'h5) ? 4'h1 << (fire - 3'h1) : 4'h0;
    assign slow_timer_exp = fire == 3'h5;
    assign aon_gpio_wake = fire == 3'h6 ? 8'h80 : 8'h00;
    assign copro_wake = fire == 3'h7;
endmodule

// *** tb_power_mode_controller.sv ***
// Purpose: directed scenarios for the power mode controller
// Assumes: inputs move on rising edges, outputs read on falling ones
// Notes: boot waits are fixed since the boot length is fixed
`timescale 1ns/100ps
module tb_power_mode_controller;
    logic clock = 1'h0, nrst = 1'h0, power_up_pin = 1'h1, chip_en = 1'h1, sleep_req = 1'h0;
    logic copro_keep = 1'h0, wireless_en = 1'h0, assoc_en = 1'h0, sensor_en = 1'h0;
    logic periph_fast = 1'h0, modem_idle = 1'h0, modem_due = 1'h0, slow_timer_exp, copro_wake;
    logic [3:0] wake_en = 4'h0, wake_evt;
    logic [7:0] cpu_load = 8'h00, aon_gpio_wake;
    logic [2:0] fire = 3'h0;
    logic cpu_pwr, cpu_run, cpu_boot, radio_pwr, aon_pwr, aon_fast_mem_cpu, aon_slow_mem_pwr;
    logic aon_recovery_pwr, copro_pwr, fast_osc_en, slow_timer_en, aon_gpio_en, adc_run;
    pmc_pkg::pmc_state_t sleep_target = pmc_pkg::PMC_ACTIVE, mode;
    pmc_pkg::pmc_speed_t cpu_speed;
    int n_mismatch = 0, cmp_count = 0, cycles = 0;
    pmc_ctrl dut (.*);
    pmc_wake_src u_src (.*);
    initial forever #20 clock = ~clock;
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        n_mismatch += int'(got !== exp);
        if (got !== exp) $display("[FAIL] %s expected %h seen %h", what, exp, got);
    endtask
    // one request or wake code, then three cycles to settle
    task automatic step(pmc_pkg::pmc_state_t st, logic [3:0] en, logic [2:0] code);
        @(posedge clock);
        wake_en <= en;
        sleep_target <= st;
        sleep_req <= code == 3'h0;
        fire <= code;
        @(posedge clock);
        sleep_req <= 1'h0;
        fire <= 3'h0;
        repeat (3) @(negedge clock);
    endtask
    task automatic t_light;
        chk("active", 8'h0F, 8'({mode, cpu_run, radio_pwr, aon_pwr, copro_pwr}));
        for (int b = 0; b < 4; b++) begin
            step(pmc_pkg::PMC_LIGHT, 4'h0, 3'h0);
            chk("light", 8'h29, 8'({mode, cpu_pwr, cpu_run, radio_pwr, copro_pwr}));
            step(pmc_pkg::PMC_LIGHT, 4'hF ^ (4'h1 << b), 3'(b + 1));
            chk("masked", 8'h02, 8'(mode));
            step(pmc_pkg::PMC_LIGHT, 4'h1 << b, 3'(b + 1));
            chk("woken", 8'h02, 8'({mode, cpu_run, cpu_boot}));
        end
        $display("t_light done");
    endtask
    task automatic t_modem;
        logic [7:0] ld [4] = '{8'hC0, 8'h21, 8'h20, 8'h20};
        logic [1:0] sp [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
        @(posedge clock);
        wireless_en <= 1'h1;
        modem_idle <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            cpu_load <= ld[k];
            periph_fast <= k == 3;
            repeat (3) @(negedge clock);
            chk("speed", 8'({3'h1, 1'h0, sp[k]}), 8'({mode, radio_pwr, cpu_speed}));
        end
        step(pmc_pkg::PMC_MODEM, 4'h0, 3'h0);
        chk("modem refuse", 8'h01, 8'(mode));
        @(posedge clock);
        modem_idle <= 1'h0;
        modem_due <= 1'h1;
        repeat (3) @(negedge clock);
        chk("modem back", 8'h01, 8'({mode, radio_pwr}));
        @(posedge clock);
        modem_due <= 1'h0;
        wireless_en <= 1'h0;
        assoc_en <= 1'h1;
        modem_idle <= 1'h1;
        repeat (3) @(negedge clock);
        chk("assoc modem", 8'h02, 8'({mode, radio_pwr}));
        @(posedge clock);
        modem_idle <= 1'h0;
        modem_due <= 1'h1;
        repeat (3) @(negedge clock);
        chk("assoc back", 8'h01, 8'({mode, radio_pwr}));
        @(posedge clock);
        modem_due <= 1'h0;
        $display("t_modem done");
    endtask
    task automatic t_deep;
        int n = 0;
        @(posedge clock);
        copro_keep <= 1'h1;
        sensor_en <= 1'h1;
        step(pmc_pkg::PMC_DEEP, 4'h0, 3'h0);
        chk("deep", 8'h07, 8'({cpu_pwr, copro_pwr, aon_slow_mem_pwr, aon_gpio_en}));
        repeat (200) begin
            @(negedge clock);
            n += int'(adc_run);
        end
        chk("adc", 8'h02, 8'(n));
        step(pmc_pkg::PMC_DEEP, 4'h0, 3'h7);
        chk("boot", 8'h36, 8'({mode, cpu_boot, aon_fast_mem_cpu, cpu_run}));
        repeat (12) @(negedge clock);
        @(posedge clock);
        copro_keep <= 1'h0;
        step(pmc_pkg::PMC_DEEP, 4'h0, 3'h0);
        chk("no copro", 8'h00, 8'(copro_pwr));
        step(pmc_pkg::PMC_DEEP, 4'h0, 3'h5);
        repeat (12) @(negedge clock);
        chk("timer wake", 8'h00, 8'({mode, cpu_boot}));
        $display("t_deep done");
    endtask
    task automatic t_hiber;
        step(pmc_pkg::PMC_HIBER, 4'hF, 3'h0);
        chk("hiber", 8'h03, 8'({fast_osc_en, copro_pwr, aon_recovery_pwr, slow_timer_en, aon_gpio_en}));
        step(pmc_pkg::PMC_HIBER, 4'hF, 3'h2);
        chk("hiber hold", 8'h04, 8'(mode));
        step(pmc_pkg::PMC_HIBER, 4'hF, 3'h6);
        chk("gpio wake", 8'h06, 8'(mode));
        repeat (12) @(negedge clock);
        $display("t_hiber done");
    endtask
    task automatic t_off;
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            chip_en <= p == 1;
            power_up_pin <= p == 0;
            repeat (3) @(negedge clock);
            chk("off", 8'h28, 8'({mode, cpu_pwr, aon_pwr, slow_timer_en}));
        end
        $display("t_off done");
    endtask
    task automatic tally_and_finish(logic hung);
        n_mismatch += int'(hung);
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) tally_and_finish(1'h1);
    end
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'h1;
        repeat (14) @(negedge clock);
        t_light;
        t_modem;
        t_deep;
        t_hiber;
        t_off;
        tally_and_finish(1'h0);
    end
endmodule
